// File: verilog/rfwd_pkg.sv
// Package with constants and carrier types for the register file window decode block.
// How it works
// - Reset clears page selector, both nibbles.
// - Page selector ignored; every access hits page zero.
// - Direct addressing of top 64 means set 1.
// - Top 32 of set 1 has two banks.
// - Reset selects bank zero.
// - Lower 32 of set 1 are unbanked.
// - Set 2 is separate 64 byte storage.
// - Direct addressing of top 64 reaches set 1.
// - Indirect or indexed top 64 reaches set 2.
// - Lowest 192 bytes open to all modes.
// - Byte or pair via 4-bit or 8-bit fields.
// - File split into 32 eight-byte slices.
// - Slice pointers mapped at their two addresses.
// - Reset points slices at common area halves.
// - Pair set loads operand and operand plus eight.
// - Working accesses reach only the two slices.
// - Working accesses never reach set 2.
// - Field top bit picks pointer, concatenate bits.
// - Upper nibble 1100B marks working register reference.
// - Pairs: even address holds the high byte.
package rfwd_pkg;

	// Register offsets and reset values.
	localparam logic [7:0] SLICE_A_OFS = 8'hD6;
	localparam logic [7:0] SLICE_B_OFS = 8'hD7;
	localparam logic [7:0] PAGE_SEL_OFS = 8'hDF;
	localparam logic [7:0] PAGE_SEL_RST = 8'h00;
	localparam logic [7:0] SLICE_A_RST = 8'hC0;
	localparam logic [7:0] SLICE_B_RST = 8'hC8;
	localparam logic BANK_RST = 1'h0;

	// Address map boundaries of the register file.
	localparam logic [7:0] SET_BASE = 8'hC0;
	localparam logic [7:0] SYS_BASE = 8'hD0;
	localparam logic [7:0] BANK_BASE = 8'hE0;
	localparam logic [3:0] WORK_PREFIX = 4'hC;
	localparam logic [7:0] SLICE_STEP = 8'h08;

	// Positions of each area inside the flat storage array.
	localparam int FLAT_DEPTH = 336;
	localparam logic [8:0] COMMON_FLAT = 9'h0C0;
	localparam logic [8:0] SET2_FLAT = 9'h0D0;
	localparam logic [8:0] BANK0_FLAT = 9'h110;
	localparam logic [8:0] BANK1_FLAT = 9'h130;

	// Addressing modes that the core presents with a request.
	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_INDEXED,
		MODE_WORK4
	} rfwd_mode_t;

	// Storage area that an access resolves to.
	typedef enum logic [2:0] {
		AREA_PRIME,
		AREA_COMMON,
		AREA_SYS,
		AREA_BANK0,
		AREA_BANK1,
		AREA_SET2
	} rfwd_area_t;

	// Register bus request from the core.
	typedef struct packed {
		logic valid;
		logic write;
		logic pair;
		rfwd_mode_t mode;
		logic [7:0] addr;
		logic [15:0] wdata;
	} rfwd_req_t;

	// Bank and slice pointer instructions from the core.
	typedef struct packed {
		logic select_bank_zero_instr;
		logic select_bank_one_instr;
		logic set_both_slice_pointers_instr;
		logic set_first_slice_pointer_instr;
		logic set_second_slice_pointer_instr;
		logic [7:0] operand;
	} rfwd_instr_t;

	// Resolved location of one byte.
	typedef struct packed {
		rfwd_area_t area;
		logic [8:0] flat;
	} rfwd_loc_t;

	// Answer to a request, one cycle after it.
	typedef struct packed {
		logic valid;
		logic ext;
		rfwd_area_t area;
		logic [8:0] flat;
		logic [7:0] laddr;
		logic [15:0] rdata;
	} rfwd_rsp_t;

endpackage : rfwd_pkg

// File: verilog/rfwd_top.sv
// Register file window decode: set, bank and slice pointer resolution with its storage; the page selector steers nothing.
`timescale 1ns/1ps
`default_nettype none

module rfwd_top (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Register bus request and instruction controls from the core.
	input wire rfwd_pkg::rfwd_req_t req,
	input wire rfwd_pkg::rfwd_instr_t instr,
	// Answer to the core.
	output var rfwd_pkg::rfwd_rsp_t rsp,
	// Control state seen by the core.
	output logic [7:0] page_selector,
	output logic [7:0] working_slice_pointer_a,
	output logic [7:0] working_slice_pointer_b,
	output logic bank_sel
);

	// Control registers.
	logic [7:0] page_selector_ff;
	logic [7:0] slice_a_ff;
	logic [7:0] slice_b_ff;
	logic bank_ff;
	rfwd_pkg::rfwd_rsp_t rsp_ff;
	rfwd_pkg::rfwd_rsp_t nxt_rsp;

	// General purpose storage: prime, common, set 2 and both banks.
	logic [7:0] gp_mem [0:rfwd_pkg::FLAT_DEPTH-1];

	// Request decode signals.
	logic work;
	logic to_set2;
	logic [7:0] chosen_ptr;
	logic [7:0] work_la;
	logic [7:0] base_la;
	logic [7:0] lane_la [0:1];
	rfwd_pkg::rfwd_loc_t lane_loc [0:1];
	logic lane_en [0:1];
	logic lane_ext [0:1];
	logic [7:0] lane_wd [0:1];
	logic [7:0] lane_rd [0:1];

	// Maps a logical byte address onto an area and a flat storage index; the page never enters.
	function automatic rfwd_pkg::rfwd_loc_t locate(input logic [7:0] la, input logic set2, input logic bank);
		rfwd_pkg::rfwd_loc_t loc;
		loc.area = rfwd_pkg::AREA_PRIME;
		loc.flat = {1'b0, la};
		if (la < rfwd_pkg::SET_BASE) begin
			loc.area = rfwd_pkg::AREA_PRIME;
			loc.flat = {1'b0, la};
		end else if (set2) begin
			loc.area = rfwd_pkg::AREA_SET2;
			loc.flat = rfwd_pkg::SET2_FLAT + {3'h0, la[5:0]};
		end else if (la < rfwd_pkg::SYS_BASE) begin
			loc.area = rfwd_pkg::AREA_COMMON;
			loc.flat = rfwd_pkg::COMMON_FLAT + {5'h00, la[3:0]};
		end else if (la < rfwd_pkg::BANK_BASE) begin
			loc.area = rfwd_pkg::AREA_SYS;
			loc.flat = 9'h000;
		end else if (bank) begin
			loc.area = rfwd_pkg::AREA_BANK1;
			loc.flat = rfwd_pkg::BANK1_FLAT + {4'h0, la[4:0]};
		end else begin
			loc.area = rfwd_pkg::AREA_BANK0;
			loc.flat = rfwd_pkg::BANK0_FLAT + {4'h0, la[4:0]};
		end
		return loc;
	endfunction : locate

	// Working register detection and address formation.
	always_comb begin
		work = (req.mode == rfwd_pkg::MODE_WORK4) ||
			(req.mode == rfwd_pkg::MODE_DIRECT && req.addr[7:4] == rfwd_pkg::WORK_PREFIX);
		chosen_ptr = req.addr[3] ? slice_b_ff : slice_a_ff;
		work_la = {chosen_ptr[7:3], req.addr[2:0]};
		to_set2 = !work && (req.mode == rfwd_pkg::MODE_INDIRECT ||
			req.mode == rfwd_pkg::MODE_INDEXED);
		base_la = work ? work_la : req.addr;
		if (req.pair) begin
			base_la[0] = 1'b0;
		end
	end

	// Per byte lane decode; lane 0 is the even, high byte of a pair.
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign lane_la[g] = (g == 0) ? base_la : (base_la | 8'h01);
		assign lane_loc[g] = locate(lane_la[g], to_set2, bank_ff);
		assign lane_en[g] = req.valid && ((g == 0) || req.pair);
		assign lane_wd[g] = (req.pair && g == 0) ? req.wdata[15:8] : req.wdata[7:0];
		assign lane_ext[g] = lane_loc[g].area == rfwd_pkg::AREA_SYS && lane_la[g] != rfwd_pkg::SLICE_A_OFS &&
			lane_la[g] != rfwd_pkg::SLICE_B_OFS && lane_la[g] != rfwd_pkg::PAGE_SEL_OFS;
		// Read value of the lane; system registers outside this block read as zero.
		always_comb begin
			if (lane_loc[g].area != rfwd_pkg::AREA_SYS) begin
				lane_rd[g] = gp_mem[lane_loc[g].flat];
			end else if (lane_la[g] == rfwd_pkg::SLICE_A_OFS) begin
				lane_rd[g] = slice_a_ff;
			end else if (lane_la[g] == rfwd_pkg::SLICE_B_OFS) begin
				lane_rd[g] = slice_b_ff;
			end else if (lane_la[g] == rfwd_pkg::PAGE_SEL_OFS) begin
				lane_rd[g] = page_selector_ff;
			end else begin
				lane_rd[g] = 8'h00;
			end
		end
	end

	// Storage writes; storage needs no reset, so the prime area is usable at once.
	always_ff @(posedge clock) begin
		for (int i = 0; i < 2; i++) begin
			if (lane_en[i] && req.write && lane_loc[i].area != rfwd_pkg::AREA_SYS) begin
				gp_mem[lane_loc[i].flat] <= lane_wd[i];
			end
		end
	end

	// Page selector: stored and readable, but it steers nothing.
	always_ff @(posedge clock) begin
		if (rst) begin
			page_selector_ff <= rfwd_pkg::PAGE_SEL_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (lane_en[i] && req.write && lane_loc[i].area == rfwd_pkg::AREA_SYS &&
					lane_la[i] == rfwd_pkg::PAGE_SEL_OFS) begin
					page_selector_ff <= lane_wd[i];
				end
			end
		end
	end

	// Bank selection follows the bank select instructions.
	always_ff @(posedge clock) begin
		if (rst) begin
			bank_ff <= rfwd_pkg::BANK_RST;
		end else if (instr.select_bank_one_instr) begin
			bank_ff <= 1'b1;
		end else if (instr.select_bank_zero_instr) begin
			bank_ff <= 1'b0;
		end
	end

	// Slice pointers: bus writes first, so an instruction in the same cycle takes precedence.
	always_ff @(posedge clock) begin
		if (rst) begin
			slice_a_ff <= rfwd_pkg::SLICE_A_RST;
			slice_b_ff <= rfwd_pkg::SLICE_B_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (lane_en[i] && req.write && lane_loc[i].area == rfwd_pkg::AREA_SYS) begin
					if (lane_la[i] == rfwd_pkg::SLICE_A_OFS) begin
						slice_a_ff <= lane_wd[i];
					end
					if (lane_la[i] == rfwd_pkg::SLICE_B_OFS) begin
						slice_b_ff <= lane_wd[i];
					end
				end
			end
			if (instr.set_both_slice_pointers_instr) begin
				slice_a_ff <= instr.operand;
				slice_b_ff <= instr.operand + rfwd_pkg::SLICE_STEP;
			end else begin
				if (instr.set_first_slice_pointer_instr) begin
					slice_a_ff <= instr.operand;
				end
				if (instr.set_second_slice_pointer_instr) begin
					slice_b_ff <= instr.operand;
				end
			end
		end
	end

	// Next answer, built from lane 0 and, for a pair, lane 1.
	always_comb begin
		nxt_rsp.valid = req.valid;
		nxt_rsp.ext = lane_en[0] && (lane_ext[0] || (req.pair && lane_ext[1]));
		nxt_rsp.area = lane_loc[0].area;
		nxt_rsp.flat = lane_loc[0].flat;
		nxt_rsp.laddr = base_la;
		nxt_rsp.rdata = req.pair ? {lane_rd[0], lane_rd[1]} : {8'h00, lane_rd[0]};
		if (!req.valid) begin
			nxt_rsp = '0;
		end
	end

	// Answer register.
	always_ff @(posedge clock) begin
		if (rst) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff <= nxt_rsp;
		end
	end

	// Outputs come straight from the registers.
	assign rsp = rsp_ff;
	assign page_selector = page_selector_ff;
	assign working_slice_pointer_a = slice_a_ff;
	assign working_slice_pointer_b = slice_b_ff;
	assign bank_sel = bank_ff;

	// Checks on the decode and control state.
	default clocking cb @(posedge clock); endclocking

	sequence direct_top_s;
		req.valid && req.mode == rfwd_pkg::MODE_DIRECT && req.addr >= rfwd_pkg::SYS_BASE;
	endsequence

	sequence indirect_top_s;
		req.valid && (req.mode == rfwd_pkg::MODE_INDIRECT || req.mode == rfwd_pkg::MODE_INDEXED) &&
			req.addr >= rfwd_pkg::SET_BASE;
	endsequence

	sequence work4_s;
		req.valid && req.mode == rfwd_pkg::MODE_WORK4 && !req.pair;
	endsequence

	// Single byte request below set 1, in any mode but a working one.
	sequence prime_any_s;
		req.valid && req.mode != rfwd_pkg::MODE_WORK4 && req.addr < rfwd_pkg::SET_BASE && !req.pair;
	endsequence

	// Single byte direct request into the system register range.
	sequence direct_sys_s;
		req.valid && req.mode == rfwd_pkg::MODE_DIRECT && !req.pair &&
			req.addr >= rfwd_pkg::SYS_BASE && req.addr < rfwd_pkg::BANK_BASE;
	endsequence

	// Single byte direct request with the working reference prefix.
	sequence work8_s;
		req.valid && req.mode == rfwd_pkg::MODE_DIRECT && !req.pair && req.addr[7:4] == rfwd_pkg::WORK_PREFIX;
	endsequence

	page_reset_a: assert property (rst |=> page_selector == 8'h00) else $error("page selector not cleared");
	prime_page0_a: assert property (disable iff (rst) req.valid && req.mode == rfwd_pkg::MODE_DIRECT &&
		req.addr < rfwd_pkg::SET_BASE && !req.pair |=> rsp.valid && rsp.flat == {1'b0, $past(req.addr)})
		else $error("prime address moved by page");
	bank_reset_a: assert property (rst |=> !bank_sel) else $error("bank not zero after reset");
	bank_route_a: assert property (disable iff (rst) direct_top_s ##0 (req.addr >= rfwd_pkg::BANK_BASE)
		|=> rsp.area == ($past(bank_sel) ? rfwd_pkg::AREA_BANK1 : rfwd_pkg::AREA_BANK0))
		else $error("bank route wrong");
	set1_route_a: assert property (disable iff (rst) direct_top_s |=> rsp.area != rfwd_pkg::AREA_SET2)
		else $error("direct access reached set 2");
	set2_route_a: assert property (disable iff (rst) indirect_top_s |=> rsp.area == rfwd_pkg::AREA_SET2)
		else $error("indirect access missed set 2");
	work_noset2_a: assert property (disable iff (rst) work4_s |=> rsp.area != rfwd_pkg::AREA_SET2)
		else $error("working access reached set 2");
	work_addr_a: assert property (disable iff (rst) work4_s |=> rsp.laddr == {($past(req.addr[3]) ?
		$past(working_slice_pointer_b[7:3]) : $past(working_slice_pointer_a[7:3])), $past(req.addr[2:0])})
		else $error("working address formed wrong");
	ptr_reset_a: assert property (rst |=> working_slice_pointer_a == 8'hC0 && working_slice_pointer_b == 8'hC8)
		else $error("slice pointers wrong after reset");
	pair_set_a: assert property (disable iff (rst) instr.set_both_slice_pointers_instr |=>
		working_slice_pointer_a == $past(instr.operand) && working_slice_pointer_b == $past(instr.operand) + 8'h08)
		else $error("pair pointer set wrong");
	first_set_a: assert property (disable iff (rst) instr.set_first_slice_pointer_instr &&
		!instr.set_second_slice_pointer_instr && !instr.set_both_slice_pointers_instr && !(req.valid && req.write)
		|=> $stable(working_slice_pointer_b)) else $error("first pointer set touched second");

	// The second pointer instruction loads only the second pointer.
	second_set_a: assert property (disable iff (rst) instr.set_second_slice_pointer_instr &&
		!instr.set_first_slice_pointer_instr && !instr.set_both_slice_pointers_instr && !(req.valid && req.write)
		|=> $stable(working_slice_pointer_a) && working_slice_pointer_b == $past(instr.operand))
		else $error("second pointer set wrong");

	// The prime area answers every addressing mode but the 4-bit working one in place.
	prime_mode_a: assert property (disable iff (rst) prime_any_s
		|=> rsp.area == rfwd_pkg::AREA_PRIME && rsp.laddr == $past(req.addr))
		else $error("prime access left the prime area");

	// Direct access to the system range lands in the unbanked system area.
	sys_area_a: assert property (disable iff (rst) direct_sys_s |=> rsp.area == rfwd_pkg::AREA_SYS)
		else $error("system range routed wrong");

	// System registers held elsewhere raise the external flag.
	ext_flag_a: assert property (disable iff (rst) direct_sys_s ##0 (req.addr != rfwd_pkg::SLICE_A_OFS &&
		req.addr != rfwd_pkg::SLICE_B_OFS && req.addr != rfwd_pkg::PAGE_SEL_OFS) |=> rsp.ext)
		else $error("external flag missing");

	// First slice pointer reads back all eight bits.
	ptr_a_read_a: assert property (disable iff (rst) direct_sys_s ##0 (req.addr == rfwd_pkg::SLICE_A_OFS)
		|=> rsp.rdata == {8'h00, $past(working_slice_pointer_a)})
		else $error("first pointer read wrong");

	// Second slice pointer reads back all eight bits.
	ptr_b_read_a: assert property (disable iff (rst) direct_sys_s ##0 (req.addr == rfwd_pkg::SLICE_B_OFS)
		|=> rsp.rdata == {8'h00, $past(working_slice_pointer_b)})
		else $error("second pointer read wrong");

	// Page selector reads back what was stored, though it steers nothing.
	page_read_a: assert property (disable iff (rst) direct_sys_s ##0 (req.addr == rfwd_pkg::PAGE_SEL_OFS)
		|=> rsp.rdata == {8'h00, $past(page_selector)})
		else $error("page selector read wrong");

	// An 8-bit field with the working prefix forms its address like a 4-bit one.
	work8_addr_a: assert property (disable iff (rst) work8_s |=> rsp.laddr == {($past(req.addr[3]) ?
		$past(working_slice_pointer_b[7:3]) : $past(working_slice_pointer_a[7:3])), $past(req.addr[2:0])})
		else $error("8-bit working address wrong");

	// The low three field bits pick the byte inside the slice.
	slice_byte_a: assert property (disable iff (rst) work4_s |=> rsp.laddr[2:0] == $past(req.addr[2:0]))
		else $error("slice byte wrong");

	// A register pair always starts on the even address.
	pair_even_a: assert property (disable iff (rst) req.valid && req.pair |=> rsp.valid && !rsp.laddr[0])
		else $error("pair not even");

	// Every request is answered on the next cycle.
	rsp_valid_a: assert property (disable iff (rst) req.valid |=> rsp.valid)
		else $error("request not answered");

	// No request leaves an empty answer.
	rsp_idle_a: assert property (disable iff (rst) !req.valid |=> !rsp.valid && rsp.rdata == 16'h0000)
		else $error("answer without request");

	// The bank one instruction selects bank one.
	bank_one_a: assert property (disable iff (rst) instr.select_bank_one_instr |=> bank_sel)
		else $error("bank one not selected");

	// The bank zero instruction alone selects bank zero.
	bank_zero_a: assert property (disable iff (rst) instr.select_bank_zero_instr &&
		!instr.select_bank_one_instr |=> !bank_sel)
		else $error("bank zero not selected");

endmodule : rfwd_top

`default_nettype wire

// File: verification/rfwd_core_model.sv
// CPU core model that issues register bus requests and pointer instructions to the block.
`timescale 1ns/1ps
`default_nettype none

module rfwd_core_model (
	// Clock.
	input wire logic clock,
	// Requests towards the block.
	output var rfwd_pkg::rfwd_req_t req,
	output var rfwd_pkg::rfwd_instr_t instr
);

	// Idle bus and no instruction at time zero.
	initial begin
		req = '0;
		instr = '0;
	end

	// One bus cycle: held for one edge, then released with inverted data so stale values never match.
	// The core reaches the common area through working references and leaves the page selector alone
	// unless the bench asks otherwise; pointer order is up to the caller.
	task automatic access(input logic wr, input logic pr, input rfwd_pkg::rfwd_mode_t md, input logic [7:0] ad,
		input logic [15:0] wd);
		@(posedge clock);
		req <= '{valid: 1'h1, write: wr, pair: pr, mode: md, addr: ad, wdata: wd};
		@(posedge clock);
		req.valid <= 1'h0;
		req.addr <= ~ad;
		req.wdata <= ~wd;
	endtask : access

	// One-cycle instruction pulse; sel holds bank zero, bank one, both, first, second.
	task automatic op(input logic [4:0] sel, input logic [7:0] opd);
		@(posedge clock);
		instr <= {sel, opd};
		@(posedge clock);
		instr <= {5'h00, ~opd};
	endtask : op

endmodule : rfwd_core_model
`default_nettype wire

// File: verification/register_file_window_decode_tb.sv
// Self-checking testbench for the register file window decode block.
`timescale 1ns/1ps
`default_nettype none

module register_file_window_decode_tb;

	logic clock;
	logic rst;
	rfwd_pkg::rfwd_req_t req;
	rfwd_pkg::rfwd_instr_t instr;
	rfwd_pkg::rfwd_rsp_t rsp;
	logic [7:0] page_selector;
	logic [7:0] working_slice_pointer_a;
	logic [7:0] working_slice_pointer_b;
	logic bank_sel;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;

	// Design under test.
	rfwd_top dut (.clock(clock), .rst(rst), .req(req), .instr(instr), .rsp(rsp), .page_selector(page_selector),
		.working_slice_pointer_a(working_slice_pointer_a), .working_slice_pointer_b(working_slice_pointer_b),
		.bank_sel(bank_sel));

	// Core model on the far side.
	rfwd_core_model core (.clock(clock), .req(req), .instr(instr));

	// Clock at 250 MHz.
	initial begin
		clock = 1'h0;
		forever #2 clock = ~clock;
	end

	// Cuts a hang short well beyond the length of the tests.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors = num_errors + 1;
			close_out();
		end
	end

	// Compares one value and counts the result.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Bus cycle through the core; the answer is looked at once it has settled.
	task automatic bus(input logic wr, input logic pr, input rfwd_pkg::rfwd_mode_t md, input logic [7:0] ad,
		input logic [15:0] wd);
		core.access(wr, pr, md, ad, wd);
		#1;
	endtask : bus

	// Instruction pulse through the core.
	task automatic ins(input logic [4:0] sel, input logic [7:0] opd);
		core.op(sel, opd);
		#1;
	endtask : ins

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// Main sequence.
	initial begin
		rst = 1'h1;
		repeat (12) @(posedge clock);
		rst <= 1'h0;
		#1;
		chk(page_selector, 16'h0000);
		chk(working_slice_pointer_a, 16'h00C0);
		chk(working_slice_pointer_b, 16'h00C8);
		chk(bank_sel, 16'h0000);
		// Page selector is writable but must not move the prime area.
		bus(1'h1, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hDF, 16'h00A5);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hDF, 16'h0000);
		chk(rsp.rdata, 16'h00A5);
		chk(rsp.valid, 16'h0001);
		bus(1'h1, 1'h0, rfwd_pkg::MODE_DIRECT, 8'h40, 16'h005A);
		for (int m = 0; m < 3; m++) begin
			bus(1'h0, 1'h0, rfwd_pkg::rfwd_mode_t'(m), 8'h40, 16'h0000);
			chk(rsp.rdata, 16'h005A);
			chk(rsp.flat, 16'h0040);
		end
		// Set 1 banks against set 2 at the same address.
		bus(1'h1, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hE5, 16'h0011);
		bus(1'h1, 1'h0, rfwd_pkg::MODE_INDIRECT, 8'hE5, 16'h0022);
		ins(5'h08, 8'h00);
		chk(bank_sel, 16'h0001);
		bus(1'h1, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hE5, 16'h0033);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hE5, 16'h0000);
		chk(rsp.rdata, 16'h0033);
		chk(rsp.area, rfwd_pkg::AREA_BANK1);
		ins(5'h10, 8'h00);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hE5, 16'h0000);
		chk(rsp.rdata, 16'h0011);
		chk(rsp.area, rfwd_pkg::AREA_BANK0);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_INDEXED, 8'hE5, 16'h0000);
		chk(rsp.rdata, 16'h0022);
		chk(rsp.area, rfwd_pkg::AREA_SET2);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hD0, 16'h0000);
		chk(rsp.ext, 16'h0001);
		chk(rsp.area, rfwd_pkg::AREA_SYS);
		// Slice pointer instructions.
		ins(5'h04, 8'h70);
		chk({working_slice_pointer_a, working_slice_pointer_b}, 16'h7078);
		ins(5'h01, 8'h48);
		chk({working_slice_pointer_a, working_slice_pointer_b}, 16'h7048);
		ins(5'h02, 8'hA0);
		chk({working_slice_pointer_a, working_slice_pointer_b}, 16'hA048);
		// Working references in both field widths.
		bus(1'h0, 1'h0, rfwd_pkg::MODE_WORK4, 8'h06, 16'h0000);
		chk(rsp.laddr, 16'h00A6);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hCB, 16'h0000);
		chk(rsp.laddr, 16'h004B);
		// Pointer aimed at set 1 top reaches the bank, never set 2; low bits read back.
		bus(1'h1, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hD7, 16'h00E3);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'hD7, 16'h0000);
		chk(rsp.rdata, 16'h00E3);
		chk(working_slice_pointer_b, 16'h00E3);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_WORK4, 8'h0D, 16'h0000);
		chk(rsp.laddr, 16'h00E5);
		chk(rsp.rdata, 16'h0011);
		chk(rsp.area, rfwd_pkg::AREA_BANK0);
		// Register pair: even byte holds the high half.
		bus(1'h1, 1'h1, rfwd_pkg::MODE_DIRECT, 8'h41, 16'h1234);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'h40, 16'h0000);
		chk(rsp.rdata, 16'h0012);
		bus(1'h0, 1'h0, rfwd_pkg::MODE_DIRECT, 8'h41, 16'h0000);
		chk(rsp.rdata, 16'h0034);
		bus(1'h0, 1'h1, rfwd_pkg::MODE_INDIRECT, 8'h41, 16'h0000);
		chk(rsp.rdata, 16'h1234);
		chk(rsp.laddr, 16'h0040);
		close_out();
	end

endmodule : register_file_window_decode_tb
`default_nettype wire
